// file: rtl/dscp_pkg.sv
// Notes on behaviour
// - Protocol pin high selects two-wire, low SPI.
// - Two-wire slave handles 100 and 400 Kbps.
// - Two-wire writes one byte; reads single or sequential.
// - Address is five fixed bits plus two straps.
// - Straps select among four slave addresses.
// - Override register bit 7 replaces fixed bits.
// - Soft reset forces default bits; 0x00 exits.
// - Write: address, register, data, each acknowledged.
// - Single read: set address, restart, one byte.
// - Acknowledged read byte advances address, sends next.
// - SPI enabled while chip select is low.
// - SPI frame: command, address, data, 24 bits.
// - Transmit on falling edge, sample on rising.
// - First read bit after 16th rising edge.
// - SPI write delivers strobe, address, data.
// - SPI read presents address, serializes returned byte.
// - No echo of incoming data on output.
// - One register per frame, no bursts.
// - Top offset of every page holds page.
// - Only eighth command bit selects write or read.
package dscp_pkg;

  // Register offsets and reset values.
  localparam logic [7:0] OFS_ADDR_OVR   = 8'h2a;
  localparam logic [7:0] OFS_SOFT_RST   = 8'hfe;
  localparam logic [7:0] OFS_PAGE       = 8'hff;
  localparam logic [7:0] PAGE_ZERO      = 8'h00;
  localparam logic [7:0] RST_ADDR_OVR   = 8'h00;
  localparam logic [7:0] RST_SOFT_RST   = 8'h00;
  localparam logic [7:0] RST_PAGE       = 8'h00;
  localparam logic [7:0] SOFT_RST_ENTER = 8'h01;
  localparam logic [7:0] SOFT_RST_EXIT  = 8'h00;

  // Slave address layout.
  localparam logic [4:0] I2C_ADDR_HI_DEF = 5'h1a;
  localparam int         OVR_EN_BIT      = 7;
  localparam int         OVR_HI_MSB      = 6;
  localparam int         OVR_HI_LSB      = 2;

  // Bit rates and serial clock limits.
  localparam int SYS_CLK_MHZ    = 100;
  localparam int I2C_STD_KBPS   = 100;
  localparam int I2C_FAST_KBPS  = 400;
  localparam int SPI_FMAX_MHZ   = 20;
  localparam int SYNC_CYCLES    = 2;

  // SPI frame positions, counted in rising edges minus one.
  localparam logic [4:0] SPI_CMD_LAST  = 5'h07;
  localparam logic [4:0] SPI_ADDR_LAST = 5'h0f;
  localparam logic [4:0] SPI_DATA_LAST = 5'h17;
  localparam logic [4:0] SPI_RD_FIRST  = 5'h10;
  localparam logic [4:0] SPI_FRAME_END = 5'h18;
  localparam logic [2:0] BIT_LAST      = 3'h7;

  // One register access request.
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dscp_acc_type;

  // Fields captured from one SPI frame.
  typedef struct packed {
    logic       cmd_wr;
    logic [7:0] addr;
    logic [7:0] data;
  } dscp_spi_frame_type;

  // Two-wire slave states.
  typedef enum logic [9:0] {
    I2C_IDLE    = 10'h001,
    I2C_ADDR    = 10'h002,
    I2C_ADDR_AK = 10'h004,
    I2C_REG     = 10'h008,
    I2C_REG_AK  = 10'h010,
    I2C_WDATA   = 10'h020,
    I2C_WD_AK   = 10'h040,
    I2C_RDATA   = 10'h080,
    I2C_RD_AK   = 10'h100,
    I2C_WAIT    = 10'h200
  } dscp_i2c_state_type;

endpackage : dscp_pkg

// file: rtl/dscp_spi_link.sv
`timescale 1ns/10ps
module dscp_spi_link (
  input  wire logic                         spi_clk_i,
  input  wire logic                         rstn_i,
  input  wire logic                         chip_select_n_i,
  input  wire logic                         protocol_select_pin_i,
  input  wire logic                         mosi_i,
  input  wire logic [7:0]                   rdata_i,
  output dscp_pkg::dscp_spi_frame_type      frame_o,
  output logic                              wr_tgl_o,
  output logic                              rd_tgl_o,
  output logic                              sdo_o,
  output logic                              sdo_oe_o
);
  import dscp_pkg::*;

  logic       spi_rst;
  logic [4:0] cnt_ff;
  logic [6:0] sh_ff;
  logic [6:0] tx_ff;

  // Frame logic is held in reset while chip select is high or two-wire mode is set.
  // select enables access
  assign spi_rst = ~rstn_i | chip_select_n_i | protocol_select_pin_i;

  // Rising edges count bits and shift in data; the count stops at the frame end.
  // sample on rising
  always_ff @(posedge spi_clk_i or posedge spi_rst) begin
    if (spi_rst) begin
      cnt_ff <= '0;
      sh_ff  <= '0;
    end else if (cnt_ff != SPI_FRAME_END) begin
      cnt_ff <= cnt_ff + 5'h01;
      sh_ff  <= {sh_ff[5:0], mosi_i};
    end
  end

  // Held frame fields and event toggles survive chip select for the crossing.
  // eighth bit decides
  always_ff @(posedge spi_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      frame_o  <= '0;
      wr_tgl_o <= 1'b0;
      rd_tgl_o <= 1'b0;
    end else if (!chip_select_n_i && !protocol_select_pin_i) begin
      if (cnt_ff == SPI_CMD_LAST) begin
        frame_o.cmd_wr <= mosi_i;
      end
      if (cnt_ff == SPI_ADDR_LAST) begin
        frame_o.addr <= {sh_ff, mosi_i};
        if (!frame_o.cmd_wr) begin
          rd_tgl_o <= ~rd_tgl_o;
        end
      end
      if (cnt_ff == SPI_DATA_LAST) begin
        frame_o.data <= {sh_ff, mosi_i};
        if (frame_o.cmd_wr) begin
          wr_tgl_o <= ~wr_tgl_o;
        end
      end
    end
  end

  // Falling edges drive read data only; nothing received is looped back.
  // first bit timing
  always_ff @(negedge spi_clk_i or posedge spi_rst) begin
    if (spi_rst) begin
      sdo_o    <= 1'b0;
      sdo_oe_o <= 1'b0;
      tx_ff    <= '0;
    end else if (cnt_ff == SPI_RD_FIRST && !frame_o.cmd_wr) begin
      sdo_o    <= rdata_i[7];
      sdo_oe_o <= 1'b1;
      tx_ff    <= rdata_i[6:0];
    end else if (cnt_ff == SPI_FRAME_END) begin
      sdo_oe_o <= 1'b0;
    end else if (sdo_oe_o) begin
      sdo_o    <= tx_ff[6];
      tx_ff    <= {tx_ff[5:0], 1'b0};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_no_echo_out : assert property (
    @(posedge spi_clk_i) disable iff (spi_rst)
    sdo_oe_o |-> (!frame_o.cmd_wr && cnt_ff > SPI_RD_FIRST - 5'h01))
    else $error("serial output driven outside read data");

  a_one_access_frame : assert property (
    @(posedge spi_clk_i) disable iff (spi_rst)
    $changed(wr_tgl_o) |-> ($past(cnt_ff) == SPI_DATA_LAST))
    else $error("write event not at frame end");

  a_first_read_bit : assert property (
    @(negedge spi_clk_i) disable iff (spi_rst)
    (cnt_ff == SPI_RD_FIRST && !frame_o.cmd_wr) |=> (sdo_oe_o && sdo_o == $past(rdata_i[7])))
    else $error("first read bit not driven after 16th edge");
endmodule : dscp_spi_link

// file: rtl/dscp_sync.sv
`timescale 1ns/10ps
module dscp_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rstn_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  logic [WIDTH-1:0] meta_ff;

  // Two flip-flops per bit; only the second is read outside.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta_ff <= '0;
      q_o     <= '0;
    end else begin
      meta_ff <= d_i;
      q_o     <= meta_ff;
    end
  end
endmodule : dscp_sync

// file: rtl/dscp_top.sv
`timescale 1ns/10ps
module dscp_top (
  input  wire logic       sys_clk_i,
  input  wire logic       rstn_i,
  input  wire logic       protocol_select_pin_i,
  input  wire logic       scl_i,
  input  wire logic       serial_data_io_i,
  output logic            serial_data_io_o,
  output logic            serial_data_io_oe_o,
  input  wire logic       spi_clk_i,
  input  wire logic       chip_select_n_i,
  output logic            serial_data_out_o,
  output logic            serial_data_out_oe_o,
  input  wire logic       addr_strap_high_i,
  input  wire logic       addr_strap_low_i,
  output logic            regmap_wr_o,
  output logic            regmap_rd_o,
  output logic [7:0]      regmap_page_o,
  output logic [7:0]      regmap_addr_o,
  output logic [7:0]      regmap_wdata_o,
  input  wire logic [7:0] regmap_rdata_i,
  output logic            chip_reset_o
);
  import dscp_pkg::*;

  logic [6:0]               sync_in;
  logic [6:0]               sync_q;
  logic                     proto_s;
  logic                     scl_s;
  logic                     sda_s;
  logic                     strap_h_s;
  logic                     strap_l_s;
  logic                     wr_tgl_s;
  logic                     rd_tgl_s;
  logic                     scl_d_ff;
  logic                     sda_d_ff;
  logic                     wr_tgl_d_ff;
  logic                     rd_tgl_d_ff;
  logic                     scl_rise;
  logic                     scl_fall;
  logic                     start_det;
  logic                     stop_det;
  logic                     spi_wr_tgl;
  logic                     spi_rd_tgl;
  dscp_spi_frame_type       spi_frame;
  logic [7:0]               ovr_ff;
  logic [7:0]               soft_rst_ff;
  logic [7:0]               page_ff;
  logic [7:0]               rd_data_ff;
  logic                     rd_ext_ff;
  logic [4:0]               addr_hi;
  logic [6:0]               slave_addr;
  logic [7:0]               rx_next;
  dscp_i2c_state_type       st_ff;
  logic [2:0]               cnt_ff;
  logic [7:0]               rx_ff;
  logic [7:0]               tx_ff;
  logic [7:0]               ptr_ff;
  logic                     rw_ff;
  dscp_acc_type             i2c_req_ff;
  dscp_acc_type             acc;
  logic                     hit_ovr;
  logic                     hit_rst;
  logic                     hit_page;
  logic                     hit_int;
  logic [7:0]               int_rdata;

  ////////////////////////////////////////////////////////////////////////////
  // Pins and link toggles are brought into the system clock domain.
  assign sync_in = {protocol_select_pin_i, scl_i, serial_data_io_i, addr_strap_high_i,
                    addr_strap_low_i, spi_wr_tgl, spi_rd_tgl};

  dscp_sync #(.WIDTH(7)) u_sync (
    .clk_i  (sys_clk_i),
    .rstn_i (rstn_i),
    .d_i    (sync_in),
    .q_o    (sync_q)
  );

  assign {proto_s, scl_s, sda_s, strap_h_s, strap_l_s, wr_tgl_s, rd_tgl_s} = sync_q;

  // SPI frame logic runs on the link clock.
  dscp_spi_link u_spi (
    .spi_clk_i             (spi_clk_i),
    .rstn_i                (rstn_i),
    .chip_select_n_i       (chip_select_n_i),
    .protocol_select_pin_i (protocol_select_pin_i),
    .mosi_i                (serial_data_io_i),
    .rdata_i               (rd_data_ff),
    .frame_o               (spi_frame),
    .wr_tgl_o              (spi_wr_tgl),
    .rd_tgl_o              (spi_rd_tgl),
    .sdo_o                 (serial_data_out_o),
    .sdo_oe_o              (serial_data_out_oe_o)
  );

  // Delayed copies for edge and condition detection.
  // oversampled bus rates
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_d_ff    <= 1'b1;
      sda_d_ff    <= 1'b1;
      wr_tgl_d_ff <= 1'b0;
      rd_tgl_d_ff <= 1'b0;
    end else begin
      scl_d_ff    <= scl_s;
      sda_d_ff    <= sda_s;
      wr_tgl_d_ff <= wr_tgl_s;
      rd_tgl_d_ff <= rd_tgl_s;
    end
  end

  // Clock edges and start or stop conditions on the two-wire bus.
  assign scl_rise  = scl_s & ~scl_d_ff;
  assign scl_fall  = ~scl_s & scl_d_ff;
  assign start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
  assign stop_det  = scl_s & scl_d_ff & ~sda_d_ff & sda_s;
  assign rx_next   = {rx_ff[6:0], sda_s};

  ////////////////////////////////////////////////////////////////////////////
  // Slave address: fixed or overridden upper bits, straps below.
  // override upper bits
  assign addr_hi = (ovr_ff[OVR_EN_BIT] && soft_rst_ff != SOFT_RST_ENTER) ?
                   ovr_ff[OVR_HI_MSB:OVR_HI_LSB] : I2C_ADDR_HI_DEF;
  assign slave_addr = {addr_hi, strap_h_s, strap_l_s};

  // Two-wire slave engine: samples on rising clock, drives after falling clock.
  // two-wire when high
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      st_ff               <= I2C_IDLE;
      cnt_ff              <= '0;
      rx_ff               <= '0;
      tx_ff               <= '0;
      ptr_ff              <= '0;
      rw_ff               <= 1'b0;
      serial_data_io_oe_o <= 1'b0;
      i2c_req_ff          <= '0;
    end else begin
      i2c_req_ff.wr <= 1'b0;
      i2c_req_ff.rd <= 1'b0;
      if (!proto_s) begin
        st_ff               <= I2C_IDLE;
        serial_data_io_oe_o <= 1'b0;
      end else if (start_det) begin
        st_ff               <= I2C_ADDR;
        cnt_ff              <= '0;
        serial_data_io_oe_o <= 1'b0;
      end else if (stop_det) begin
        st_ff               <= I2C_IDLE;
        serial_data_io_oe_o <= 1'b0;
      end else begin
        case (st_ff)
          I2C_IDLE: begin
            cnt_ff <= '0;
          end
          I2C_ADDR: begin
            if (scl_rise) begin
              rx_ff  <= rx_next;
              cnt_ff <= cnt_ff + 3'h1;
              if (cnt_ff == BIT_LAST) begin
                if (rx_next[7:1] == slave_addr) begin
                  rw_ff <= rx_next[0];
                  st_ff <= I2C_ADDR_AK;
                  i2c_req_ff.rd   <= rx_next[0];
                  i2c_req_ff.addr <= ptr_ff;
                end else begin
                  st_ff <= I2C_WAIT;
                end
              end
            end
          end
          I2C_ADDR_AK: begin
            if (scl_fall) begin
              if (!serial_data_io_oe_o) begin
                serial_data_io_oe_o <= 1'b1;
              end else if (rw_ff) begin
                serial_data_io_oe_o <= ~rd_data_ff[7];
                tx_ff               <= {rd_data_ff[6:0], 1'b0};
                st_ff               <= I2C_RDATA;
              end else begin
                serial_data_io_oe_o <= 1'b0;
                st_ff               <= I2C_REG;
              end
            end
          end
          I2C_REG: begin
            if (scl_rise) begin
              rx_ff  <= rx_next;
              cnt_ff <= cnt_ff + 3'h1;
              if (cnt_ff == BIT_LAST) begin
                ptr_ff <= rx_next;
                st_ff  <= I2C_REG_AK;
              end
            end
          end
          I2C_REG_AK: begin
            if (scl_fall) begin
              serial_data_io_oe_o <= ~serial_data_io_oe_o;
              if (serial_data_io_oe_o) begin
                st_ff <= I2C_WDATA;
              end
            end
          end
          I2C_WDATA: begin
            if (scl_rise) begin
              rx_ff  <= rx_next;
              cnt_ff <= cnt_ff + 3'h1;
              if (cnt_ff == BIT_LAST) begin
                i2c_req_ff.wr    <= 1'b1;
                i2c_req_ff.addr  <= ptr_ff;
                i2c_req_ff.wdata <= rx_next;
                st_ff            <= I2C_WD_AK;
              end
            end
          end
          I2C_WD_AK: begin
            if (scl_fall) begin
              serial_data_io_oe_o <= ~serial_data_io_oe_o;
              if (serial_data_io_oe_o) begin
                st_ff <= I2C_WAIT;
              end
            end
          end
          I2C_RDATA: begin
            if (scl_fall && cnt_ff != 3'h0) begin
              serial_data_io_oe_o <= ~tx_ff[7];
              tx_ff               <= {tx_ff[6:0], 1'b0};
            end
            if (scl_rise) begin
              cnt_ff <= cnt_ff + 3'h1;
              if (cnt_ff == BIT_LAST) begin
                st_ff <= I2C_RD_AK;
              end
            end
          end
          I2C_RD_AK: begin
            if (scl_fall) begin
              serial_data_io_oe_o <= 1'b0;
            end
            if (scl_rise) begin
              if (!sda_s) begin
                ptr_ff          <= ptr_ff + 8'h01;
                i2c_req_ff.rd   <= 1'b1;
                i2c_req_ff.addr <= ptr_ff + 8'h01;
                rw_ff           <= 1'b1;
                serial_data_io_oe_o <= 1'b1;
                st_ff           <= I2C_ADDR_AK;
              end else begin
                st_ff <= I2C_WAIT;
              end
            end
          end
          I2C_WAIT: begin
            serial_data_io_oe_o <= 1'b0;
          end
          default: begin
            st_ff <= I2C_IDLE;
          end
        endcase
      end
    end
  end

  // The two-wire pin is open drain, so its driven level is always low.
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      serial_data_io_o <= 1'b0;
    end else begin
      serial_data_io_o <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access source follows the protocol pin; SPI events come from toggle edges.
  // frame fields used
  always_comb begin
    if (proto_s) begin
      acc = i2c_req_ff;
    end else begin
      acc.wr    = (wr_tgl_s ^ wr_tgl_d_ff) & spi_frame.cmd_wr;
      acc.rd    = (rd_tgl_s ^ rd_tgl_d_ff) & ~spi_frame.cmd_wr;
      acc.addr  = spi_frame.addr;
      acc.wdata = spi_frame.data;
    end
  end

  // Registers kept inside the port; page 0 holds override and soft reset.
  // page at top offset
  assign hit_ovr   = (acc.addr == OFS_ADDR_OVR) && (page_ff == PAGE_ZERO);
  assign hit_rst   = (acc.addr == OFS_SOFT_RST) && (page_ff == PAGE_ZERO);
  assign hit_page  = (acc.addr == OFS_PAGE);
  assign hit_int   = hit_ovr | hit_rst | hit_page;
  assign int_rdata = hit_page ? page_ff : (hit_ovr ? ovr_ff : soft_rst_ff);

  // Software-written control registers.
  // page steers accesses
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ovr_ff      <= RST_ADDR_OVR;
      soft_rst_ff <= RST_SOFT_RST;
      page_ff     <= RST_PAGE;
    end else if (acc.wr) begin
      if (hit_ovr) begin
        ovr_ff <= acc.wdata;
      end
      if (hit_rst) begin
        soft_rst_ff <= acc.wdata;
      end
      if (hit_page) begin
        page_ff <= acc.wdata;
      end
    end
  end

  // Outer register map strobes; read data is taken while the read strobe is high.
  // write to map
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      regmap_wr_o    <= 1'b0;
      regmap_rd_o    <= 1'b0;
      regmap_page_o  <= RST_PAGE;
      regmap_addr_o  <= '0;
      regmap_wdata_o <= '0;
      chip_reset_o   <= 1'b0;
      rd_ext_ff      <= 1'b0;
      rd_data_ff     <= '0;
    end else begin
      regmap_wr_o   <= acc.wr & ~hit_int;
      regmap_rd_o   <= acc.rd & ~hit_int;
      regmap_page_o <= page_ff;
      chip_reset_o  <= (soft_rst_ff == SOFT_RST_ENTER);
      rd_ext_ff     <= acc.rd & ~hit_int;
      if (acc.wr || acc.rd) begin
        regmap_addr_o  <= acc.addr;
        regmap_wdata_o <= acc.wdata;
      end
      if (acc.rd && hit_int) begin
        rd_data_ff <= int_rdata;
      end else if (rd_ext_ff) begin
        rd_data_ff <= regmap_rdata_i;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  sequence s_ack_start;
    st_ff == I2C_ADDR_AK && scl_fall && !serial_data_io_oe_o;
  endsequence

  a_proto_gate_spi : assert property (
    (proto_s && $changed(wr_tgl_s) && $past(proto_s)) |-> !(acc.wr && !i2c_req_ff.wr))
    else $error("SPI write taken in two-wire mode");

  a_addr_ack_drive : assert property (
    s_ack_start |=> serial_data_io_oe_o)
    else $error("address not acknowledged");

  a_write_then_wait : assert property (
    (proto_s && i2c_req_ff.wr) |=> st_ff == I2C_WD_AK)
    else $error("second write byte accepted");

  a_read_increment : assert property (
    (st_ff == I2C_RD_AK && scl_rise && !sda_s && !start_det && !stop_det && proto_s)
    |=> (ptr_ff == $past(ptr_ff) + 8'h01) && i2c_req_ff.rd)
    else $error("pointer not advanced on master ack");

  a_stop_release : assert property (
    (stop_det && proto_s) |=> (st_ff == I2C_IDLE && !serial_data_io_oe_o))
    else $error("bus not released at stop");

  a_soft_reset_out : assert property (
    (acc.wr && hit_rst && acc.wdata == SOFT_RST_ENTER) |-> ##2 chip_reset_o)
    else $error("soft reset not entered");

  a_override_addr : assert property (
    (ovr_ff[OVR_EN_BIT] && !chip_reset_o && $stable(ovr_ff) && $stable(soft_rst_ff))
    |-> addr_hi == ovr_ff[OVR_HI_MSB:OVR_HI_LSB])
    else $error("override bits not used");

  a_page_readback : assert property (
    (acc.rd && hit_page) |=> rd_data_ff == $past(page_ff) && !regmap_rd_o)
    else $error("page register read wrong");
endmodule : dscp_top

// file: test/dscp_spi_master.sv
`timescale 1ns/10ps
module dscp_spi_master (
  output logic      sclk_o,
  output logic      csn_o,
  output logic      mosi_o,
  input  wire logic miso_i,
  input  wire logic sda_i
);
  // The link clock idles low and stands still between frames.
  initial begin
    sclk_o = 1'b0;
    csn_o  = 1'b1;
    mosi_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Shift frame MSB first.
  // Data changes while the clock is low and is sampled at the rising edge.
  // The clock is held high longer after edge 16 so the read data can arrive.
  task automatic xfer(input logic [23:0] frm, input int nbits,
                      output logic [7:0] rd);
    rd    = 8'h00;
    csn_o = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      mosi_o = frm[23-i];
      #24 sclk_o = 1'b1;
      if (i > 15) rd = {rd[6:0], miso_i};
      #(i == 15 ? 80 : 24) sclk_o = 1'b0;
    end
    #24 csn_o = 1'b1;
    mosi_o = ~mosi_o;
    // Idle gap longer than two link clocks.
    #100;
  endtask : xfer

  ////////////////////////////////////////////////////////////////////////////
  // Two-wire write: start, three bytes each acknowledged, stop.
  // Data moves while the clock is low; the ninth bit of each byte is released.
  task automatic i2c_wr(input logic [23:0] bytes, output logic [2:0] nak);
    nak    = 3'h7;
    mosi_o = 1'b1;
    #100 sclk_o = 1'b1;
    #200 mosi_o = 1'b0;
    #200 sclk_o = 1'b0;
    for (int i = 0; i < 27; i++) begin
      #100 mosi_o = (i % 9 == 8) ? 1'b1 : bytes[23 - (i - i / 9)];
      #100 sclk_o = 1'b1;
      if (i % 9 == 8) nak = {nak[1:0], sda_i};
      #200 sclk_o = 1'b0;
    end
    #100 mosi_o = 1'b0;
    #100 sclk_o = 1'b1;
    #200 mosi_o = 1'b1;
    #200;
  endtask : i2c_wr
endmodule : dscp_spi_master

// file: test/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic       clk = 1'b0, rstn = 1'b0, psel = 1'b0, sclk, csn, mosi, miso, last = 1'b0;
  logic       wr, rd_s, rst_o, so, so_oe, io_o, io_oe;
  logic [7:0] page, addr, wdata, rd, wa, wd, wr_cnt = 8'h00, rd_cnt = 8'h00;
  logic [2:0] nak;
  int         error_cnt = 0, tests_run = 0, cyc = 0;

  // The system clock runs at 100 MHz.
  always #5 clk = ~clk;

  // The open-drain data line is low while the slave pulls it.
  wire sda = mosi & ~io_oe;

  dscp_spi_master m (.sclk_o(sclk), .csn_o(csn), .mosi_o(mosi), .miso_i(miso), .sda_i(sda));

  dscp_top dut (.sys_clk_i(clk), .rstn_i(rstn), .protocol_select_pin_i(psel),
    .scl_i(sclk), .serial_data_io_i(sda), .serial_data_io_o(io_o),
    .serial_data_io_oe_o(io_oe), .spi_clk_i(sclk), .chip_select_n_i(csn),
    .serial_data_out_o(so), .serial_data_out_oe_o(so_oe), .addr_strap_high_i(1'b0),
    .addr_strap_low_i(1'b1), .regmap_wr_o(wr), .regmap_rd_o(rd_s),
    .regmap_page_o(page), .regmap_addr_o(addr), .regmap_wdata_o(wdata),
    .regmap_rdata_i(addr ^ 8'h5a), .chip_reset_o(rst_o));

  // A released output line shows the inverse of its last driven value.
  assign miso = so_oe ? so : ~last;
  always @(negedge sclk) if (so_oe === 1'b1) last <= so;

  // Count write strobes to the outer map and keep the last address and data.
  always @(posedge clk) begin
    if (rd_s === 1'b1) rd_cnt <= rd_cnt + 8'h01;
    if (wr === 1'b1) begin
      wr_cnt <= wr_cnt + 8'h01;
      wa     <= addr;
      wd     <= wdata;
    end
  end

  // Compare one value and report a mismatch.
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    tests_run++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // Print the counts and the verdict, then stop.
  task automatic results();
    $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : results

  // Cut a hang short after a cycle ceiling.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      error_cnt++;
      results();
    end
  end

  // Main sequence of frames with expected values.
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (5) @(posedge clk);
    m.xfer(24'hff_33a5, 24, rd);
    chk("wr count", 8'h01, wr_cnt);
    chk("wr addr", 8'h33, wa);
    chk("wr data", 8'ha5, wd);
    m.xfer(24'hfe_4400, 24, rd);
    chk("rd data", 8'h1e, rd);
    chk("rd strobe", 8'h01, rd_cnt);
    chk("rd no wr", 8'h01, wr_cnt);
    chk("sdo oe", 8'h00, {7'h00, so_oe});
    $display("test spi write read done");
    m.xfer(24'hff_5566, 20, rd);
    chk("short frame", 8'h01, wr_cnt);
    m.xfer(24'h01_fe01, 24, rd);
    chk("chip reset on", 8'h01, {7'h00, rst_o});
    m.xfer(24'h01_fe00, 24, rd);
    chk("chip reset off", 8'h00, {7'h00, rst_o});
    $display("test soft reset done");
    m.xfer(24'h01_ff03, 24, rd);
    chk("page out", 8'h03, page);
    chk("page no wr", 8'h01, wr_cnt);
    m.xfer(24'h00_ff00, 24, rd);
    chk("page read", 8'h03, rd);
    chk("page no rd", 8'h01, rd_cnt);
    $display("test page done");
    @(posedge clk);
    psel <= 1'b1;
    repeat (4) @(posedge clk);
    m.xfer(24'h01_3377, 24, rd);
    chk("spi off", 8'h01, wr_cnt);
    $display("test protocol select done");
    m.i2c_wr(24'hd2_5566, nak);
    chk("i2c acks", 8'h00, {5'h00, nak});
    chk("i2c wr count", 8'h02, wr_cnt);
    chk("i2c wr addr", 8'h55, wa);
    chk("i2c wr data", 8'h66, wd);
    chk("sda out", 8'h00, {7'h00, io_o});
    chk("sda released", 8'h00, {7'h00, io_oe});
    $display("test two-wire write done");
    results();
  end
endmodule : testbench
